// ---- logic/psrc_ctrl.v ----
// Operation
// - Read cycle between grade minimum and 10 us
// - Cycle spans select/address settle to release
// - Same-address reads each meet minimum, total bounded
// - Address skew under select at most limit
// - Skew limit void while select inactive
// - Write cycle between grade minimum and 10 us
// - Same-address writes total bounded by 10 us
// - Select 40, bytes 30, address 35 before end
// - Hold byte selects 20 ns after end
// - Data 20 ns before end, zero hold
`include "psram_consts.vh"

module psrc_ctrl #(
    parameter AW        = `PSRC_ADDR_W,
    parameter DW        = `PSRC_DATA_W,
    // Per-grade figures, ns
    parameter T_RC_NS   = `PSRC_T_RC_NS,
    parameter T_WC_NS   = `PSRC_T_WC_NS,
    parameter T_AA_NS   = `PSRC_T_AA_NS,
    parameter T_OE_NS   = `PSRC_T_OE_NS,
    parameter T_CW_NS   = `PSRC_T_CW_NS,
    parameter T_BW_NS   = `PSRC_T_BW_NS,
    parameter T_AW_NS   = `PSRC_T_AW_NS,
    parameter T_WP_NS   = `PSRC_T_WP_NS,
    parameter T_WR_NS   = `PSRC_T_WR_NS,
    parameter T_BWH_NS  = `PSRC_T_BWH_NS,
    parameter T_DW_NS   = `PSRC_T_DW_NS,
    parameter T_CP_NS   = `PSRC_T_CP_NS,
    parameter T_CHZ_NS  = `PSRC_T_CHZ_NS
) (
    input  wire          clk_sys,
    input  wire          rst,
    // User request side
    input  wire          req_valid,
    input  wire          req_write,
    input  wire [AW-1:0] req_addr,
    input  wire [DW-1:0] req_wdata,
    input  wire [1:0]    req_be,
    output reg           req_ready,
    output reg           rsp_valid,
    output reg  [DW-1:0] rsp_rdata,
    // RAM pins
    output reg  [AW-1:0] ram_addr,
    output reg           ram_select_n,
    output reg           ram_oe_n,
    output reg           ram_we_n,
    output reg           low_byte_select_n,
    output reg           high_byte_select_n,
    output reg  [DW-1:0] ram_dq_o,
    output reg           ram_dq_oe,
    input  wire [DW-1:0] ram_dq_i
);
    // -------------------------------------------------------------
    // Cycle counts
    // -------------------------------------------------------------
    localparam CW = `PSRC_CNT_W;
    // Read: wait access plus three cycles (two sync stages, capture), at least full cycle
    localparam integer RD_ACC  = `PSRC_MIN_CYC(T_AA_NS) + 3;
    localparam integer RD_MIN  = `PSRC_MIN_CYC(T_RC_NS);
    localparam integer RD_CYC  = (RD_ACC > RD_MIN) ? RD_ACC : RD_MIN;
    // Write pulse covers pulse width, select, bytes, address, data
    localparam integer WP_A    = `PSRC_MIN_CYC(T_WP_NS);
    localparam integer WP_B    = `PSRC_MIN_CYC(T_CW_NS);
    localparam integer WP_C    = `PSRC_MIN_CYC(T_AW_NS);
    localparam integer WP_D    = `PSRC_MIN_CYC(T_BW_NS);
    localparam integer WP_E    = `PSRC_MIN_CYC(T_DW_NS);
    localparam integer WP_AB   = (WP_A > WP_B) ? WP_A : WP_B;
    localparam integer WP_CD   = (WP_C > WP_D) ? WP_C : WP_D;
    localparam integer WP_ABCD = (WP_AB > WP_CD) ? WP_AB : WP_CD;
    localparam integer WP_CYC  = (WP_ABCD > WP_E) ? WP_ABCD : WP_E;
    // Recovery after write end: covers both write recovery and byte hold
    localparam integer WR_A    = `PSRC_MIN_CYC(T_WR_NS);
    localparam integer WR_B    = `PSRC_MIN_CYC(T_BWH_NS);
    localparam integer WR_CYC  = (WR_A > WR_B) ? WR_A : WR_B;
    localparam integer WC_MIN  = `PSRC_MIN_CYC(T_WC_NS);
    // Whole write: one setup cycle, pulse, recovery; stretched to minimum
    localparam integer WR_SUM  = 1 + WP_CYC + WR_CYC;
    localparam integer WR_PAD  = (WR_SUM >= WC_MIN) ? 0 : (WC_MIN - WR_SUM);
    // Idle between cycles: select high pulse and bus float time
    localparam integer GAP_A   = `PSRC_MIN_CYC(T_CP_NS);
    localparam integer GAP_B   = `PSRC_MIN_CYC(T_CHZ_NS);
    localparam integer GAP_CYC = (GAP_A > GAP_B) ? GAP_A : GAP_B;

    // -------------------------------------------------------------
    // States
    // -------------------------------------------------------------
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_RD    = 3'h1;
    localparam [2:0] S_WSET  = 3'h2;
    localparam [2:0] S_WP    = 3'h3;
    localparam [2:0] S_WREC  = 3'h4;
    localparam [2:0] S_GAP   = 3'h5;

    reg  [2:0]    state;
    reg  [CW-1:0] cnt;
    wire [DW-1:0] dq_sync;

    psrc_sync #(
        .W (DW)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (ram_dq_i),
        .q       (dq_sync)
    );

    // -------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------
    // Each access is a full select-low cycle; select rises between
    // accesses, so address moves only while deselected and no
    // same-address run can ever grow toward the 10 us ceiling.
    always @(posedge clk_sys) begin
        if (rst) begin
            state              <= S_IDLE;
            cnt                <= {CW{1'b0}};
            req_ready          <= 1'b0;
            rsp_valid          <= 1'b0;
            rsp_rdata          <= {DW{1'b0}};
            ram_addr           <= {AW{1'b0}};
            ram_select_n       <= 1'b1;
            ram_oe_n           <= 1'b1;
            ram_we_n           <= 1'b1;
            low_byte_select_n  <= 1'b1;
            high_byte_select_n <= 1'b1;
            ram_dq_o           <= {DW{1'b0}};
            ram_dq_oe          <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                S_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        // Address set while deselected, no skew limit
                        ram_addr           <= req_addr;
                        ram_select_n       <= 1'b0;
                        low_byte_select_n  <= ~req_be[0];
                        high_byte_select_n <= ~req_be[1];
                        cnt                <= {CW{1'b0}};
                        if (req_write) begin
                            ram_dq_o  <= req_wdata;
                            ram_dq_oe <= 1'b1;
                            state     <= S_WSET;
                        end else begin
                            ram_oe_n <= 1'b0;
                            state    <= S_RD;
                        end
                    end
                end
                S_RD: begin
                    // Sample after access time plus sync delay
                    if (cnt == RD_CYC[CW-1:0] - 1'b1) begin
                        rsp_rdata          <= dq_sync;
                        rsp_valid          <= 1'b1;
                        ram_select_n       <= 1'b1;
                        ram_oe_n           <= 1'b1;
                        low_byte_select_n  <= 1'b1;
                        high_byte_select_n <= 1'b1;
                        cnt                <= {CW{1'b0}};
                        state              <= S_GAP;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                S_WSET: begin
                    // Address one cycle ahead of write start
                    ram_we_n <= 1'b0;
                    cnt      <= {CW{1'b0}};
                    state    <= S_WP;
                end
                S_WP: begin
                    if (cnt == WP_CYC[CW-1:0] - 1'b1) begin
                        ram_we_n <= 1'b1;
                        cnt      <= {CW{1'b0}};
                        state    <= S_WREC;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                S_WREC: begin
                    // Bytes, select and address held through recovery
                    if (cnt == WR_CYC[CW-1:0] + WR_PAD[CW-1:0] - 1'b1) begin
                        ram_select_n       <= 1'b1;
                        low_byte_select_n  <= 1'b1;
                        high_byte_select_n <= 1'b1;
                        ram_dq_oe          <= 1'b0;
                        rsp_valid          <= 1'b1;
                        cnt                <= {CW{1'b0}};
                        state              <= S_GAP;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                S_GAP: begin
                    // Lets the RAM float before the next cycle
                    if (cnt == GAP_CYC[CW-1:0] - 1'b1) begin
                        cnt       <= {CW{1'b0}};
                        req_ready <= 1'b1;
                        state     <= S_IDLE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
    // Timing figures are parameters so any grade fits
endmodule

// ---- logic/psram_consts.vh ----
`ifndef PSRAM_CONSTS_VH
`define PSRAM_CONSTS_VH

// Clock period in ps (200 MHz)
`define PSRC_CLK_PS        5000
// Fastest-grade timing figures, ns
`define PSRC_T_RC_NS       80
`define PSRC_T_RC_MAX_NS   10000
`define PSRC_T_WC_NS       80
`define PSRC_T_AA_NS       80
`define PSRC_T_OE_NS       35
`define PSRC_T_CW_NS       40
`define PSRC_T_BW_NS       30
`define PSRC_T_AW_NS       35
`define PSRC_T_WP_NS       30
`define PSRC_T_WR_NS       20
`define PSRC_T_BWH_NS      20
`define PSRC_T_DW_NS       20
`define PSRC_T_CP_NS       10
`define PSRC_T_CHZ_NS      25
// Least times round up, longest round down
`define PSRC_MIN_CYC(ns)   (((ns) * 1000 + `PSRC_CLK_PS - 1) / `PSRC_CLK_PS)
`define PSRC_MAX_CYC(ns)   (((ns) * 1000) / `PSRC_CLK_PS)
// Widths
`define PSRC_ADDR_W        20
`define PSRC_DATA_W        16
// Counter width
`define PSRC_CNT_W         12

`endif

// ---- logic/psrc_sync.v ----
// Two-stage synchroniser for the read data bus
module psrc_sync #(
    parameter W = 16
) (
    input  wire         clk_sys,
    input  wire         rst,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta;

    always @(posedge clk_sys) begin
        if (rst) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ---- verification/psrc_ram_model.sv ----
module psrc_ram_model (
    input  wire logic [19:0] ram_addr,
    input  wire logic        ram_select_n,
    input  wire logic        ram_oe_n,
    input  wire logic        ram_we_n,
    input  wire logic        low_byte_select_n,
    input  wire logic        high_byte_select_n,
    input  wire logic [15:0] ram_dq_o,
    output logic      [15:0] ram_dq_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:1048575];
    wire         rd_on = !ram_select_n && !ram_oe_n && ram_we_n;
    wire  [15:0] mask = {{8{!high_byte_select_n}}, {8{!low_byte_select_n}}};
    initial ram_dq_i = 16'h0000;
    // Released lines flip, so stale data never passes as fresh
    always @(rd_on or mask or ram_addr) begin
        ram_dq_i <= #25 ~ram_dq_i;
        if (rd_on) ram_dq_i <= #35 (mem[ram_addr] & mask) | (~ram_dq_i & ~mask);
    end
    always @(posedge ram_we_n) begin
        if (!ram_select_n && !low_byte_select_n) mem[ram_addr][7:0] <= ram_dq_o[7:0];
        if (!ram_select_n && !high_byte_select_n) mem[ram_addr][15:8] <= ram_dq_o[15:8];
    end
endmodule

// ---- verification/psrc_ctrl_assertions.sv ----
module psrc_ctrl_assertions #(
    parameter AW = 20,
    parameter DW = 16
) (
    input wire logic          clk_sys,
    input wire logic          rst,
    input wire logic          req_valid,
    input wire logic          req_write,
    input wire logic          req_ready,
    input wire logic          rsp_valid,
    input wire logic [AW-1:0] ram_addr,
    input wire logic          ram_select_n,
    input wire logic          ram_oe_n,
    input wire logic          ram_we_n,
    input wire logic          low_byte_select_n,
    input wire logic          high_byte_select_n,
    input wire logic [DW-1:0] ram_dq_o,
    input wire logic          ram_dq_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [11:0] low_cnt;
    wire  [1:0]  bsel = {high_byte_select_n, low_byte_select_n};
    always @(posedge clk_sys) begin
        low_cnt <= (rst || ram_select_n) ? 12'h000 : low_cnt + 12'h001;
    end
    sequence s_we_fall; $fell(ram_we_n); endsequence
    sequence s_we_rise; $rose(ram_we_n); endsequence
    property p_cyc_min; $fell(ram_select_n) |-> !ram_select_n[*8] ##1 !ram_select_n[*8]; endproperty
    a_cyc_min: assert property (p_cyc_min) else $error("cycle too short");
    property p_cyc_max; low_cnt < 12'h7d0; endproperty
    a_cyc_max: assert property (p_cyc_max) else $error("cycle too long");
    property p_addr; !ram_select_n && !$past(ram_select_n) |-> $stable(ram_addr); endproperty
    a_addr: assert property (p_addr) else $error("address moved under select");
    property p_we_pulse; s_we_fall |-> (!ram_we_n && !ram_select_n)[*6]; endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write pulse short");
    property p_wr_setup;
        s_we_rise |-> !$past(ram_select_n, 8) && $past(ram_addr, 7) == ram_addr
            && $past(bsel, 6) == bsel && $past(ram_dq_oe, 4) && $past(ram_dq_o, 4) == ram_dq_o;
    endproperty
    a_wr_setup: assert property (p_wr_setup) else $error("write setup short");
    property p_wr_rec;
        s_we_rise |-> ($stable(ram_addr) && $stable(bsel) && !ram_select_n)[*4];
    endproperty
    a_wr_rec: assert property (p_wr_rec) else $error("write recovery short");
    property p_no_fight; ram_dq_oe |-> ram_oe_n && !ram_select_n; endproperty
    a_no_fight: assert property (p_no_fight) else $error("bus contention");
    property p_rd_ans;
        req_valid && req_ready && !req_write |-> ##1 !ram_oe_n[*8] ##12 rsp_valid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
endmodule

bind psrc_ctrl psrc_ctrl_assertions #(.AW(AW), .DW(DW)) i_chk (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .ram_addr(ram_addr),
    .ram_select_n(ram_select_n), .ram_oe_n(ram_oe_n), .ram_we_n(ram_we_n),
    .low_byte_select_n(low_byte_select_n), .high_byte_select_n(high_byte_select_n),
    .ram_dq_o(ram_dq_o), .ram_dq_oe(ram_dq_oe));

// ---- verification/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        w;
        logic [19:0] a;
        logic [15:0] d;
        logic [1:0]  b;
        logic [15:0] m;
    } psrc_row_t;
    // Reads carry the expected word in d, compared under mask m
    localparam psrc_row_t ROWS [8] = '{
        '{1'b1, 20'h00000, 16'h1234, 2'b11, 16'h0000}, '{1'b1, 20'hfffff, 16'habcd, 2'b11, 16'h0000},
        '{1'b1, 20'h00000, 16'h5600, 2'b10, 16'h0000}, '{1'b0, 20'h00000, 16'h5634, 2'b11, 16'hffff},
        '{1'b0, 20'hfffff, 16'habcd, 2'b11, 16'hffff}, '{1'b1, 20'hfffff, 16'h00ef, 2'b01, 16'h0000},
        '{1'b0, 20'hfffff, 16'habef, 2'b11, 16'hffff}, '{1'b0, 20'h00000, 16'h0034, 2'b01, 16'h00ff}};
    logic        clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic [19:0] req_addr = 20'h00000;
    logic [15:0] req_wdata = 16'h0000, q;
    logic [1:0]  req_be = 2'b00;
    wire         req_ready, rsp_valid, ram_select_n, ram_oe_n, ram_we_n, ram_dq_oe;
    wire         low_byte_select_n, high_byte_select_n;
    wire  [15:0] rsp_rdata, ram_dq_o, ram_dq_i;
    wire  [19:0] ram_addr;
    int          mismatches = 0, total_checks = 0, n;
    psrc_ctrl i_dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ram_addr(ram_addr),
        .ram_select_n(ram_select_n), .ram_oe_n(ram_oe_n), .ram_we_n(ram_we_n),
        .low_byte_select_n(low_byte_select_n), .high_byte_select_n(high_byte_select_n),
        .ram_dq_o(ram_dq_o), .ram_dq_oe(ram_dq_oe), .ram_dq_i(ram_dq_i));
    psrc_ram_model i_ram (.ram_addr(ram_addr), .ram_select_n(ram_select_n), .ram_oe_n(ram_oe_n),
        .ram_we_n(ram_we_n), .low_byte_select_n(low_byte_select_n),
        .high_byte_select_n(high_byte_select_n), .ram_dq_o(ram_dq_o), .ram_dq_i(ram_dq_i));
    always #2.5 clk_sys = ~clk_sys;
    task give_verdict;
        if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cmp_word(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task step;
        @(posedge clk_sys);
        #1;
    endtask
    task chk_idle;
        cmp_word({10'h000, ram_select_n, ram_oe_n, ram_we_n, ram_dq_oe, rsp_valid, req_ready},
            16'h0038);
    endtask
    // Request held until the edge that sees ready high
    task op(input psrc_row_t r);
        req_valid = 1'b1;
        {req_write, req_addr, req_wdata, req_be} = {r.w, r.a, r.d, r.b};
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            step;
            n++;
        end
        step;
        req_valid = 1'b0;
        n = 0;
        do begin
            step;
            n++;
        end while (rsp_valid !== 1'b1 && n < 100);
        q = rsp_rdata;
        if (n >= 100) mismatches++;
    endtask
    initial begin
        #50000;
        mismatches++;
        give_verdict;
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        #1 rst = 1'b0;
        chk_idle;
        foreach (ROWS[i]) begin
            op(ROWS[i]);
            if (!ROWS[i].w) cmp_word(q & ROWS[i].m, ROWS[i].d);
            if (!ROWS[i].w) cmp_word(n[15:0], 16'h0013);
            if (ROWS[i].w) cmp_word(n[15:0], 16'h0010);
        end
        // Reset in mid read; memory must survive and pins go idle
        {req_valid, req_write, req_addr, req_be} = {1'b1, 1'b0, 20'h00000, 2'b11};
        repeat (10) step;
        rst = 1'b1;
        repeat (2) step;
        chk_idle;
        {rst, req_valid} = 2'b00;
        cmp_word({15'h0000, req_ready}, 16'h0000);
        step;
        cmp_word({15'h0000, req_ready}, 16'h0001);
        op(ROWS[6]);
        cmp_word(q, 16'habef);
        give_verdict;
    end
endmodule
